// [hdl/brfu_defines.svh]
/*
 * Holds the register offsets, command field positions, status flag positions
 * and reset values of the bit rotate and flag unit.
 * Assumes it is included by bare name into the package and brfu_top; brfu_mem does not include it.
 */
`ifndef BRFU_DEFINES_SVH
`define BRFU_DEFINES_SVH

// ----------------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define BRFU_ADDR_CMD      8'h00
`define BRFU_ADDR_STATUS   8'h04
`define BRFU_ADDR_MEM_LO   8'h20
`define BRFU_ADDR_MEM_HI   8'h5c
`define BRFU_MEM_IDX_BASE  5'h08

// ----------------------------------------------------------------------------
// command word fields
// ----------------------------------------------------------------------------
`define BRFU_CMD_OP_LSB    0
`define BRFU_CMD_OP_MSB    3
`define BRFU_CMD_IDX_LSB   4
`define BRFU_CMD_IDX_MSB   6
`define BRFU_CMD_BIT_LSB   8
`define BRFU_CMD_BIT_MSB   10

// ----------------------------------------------------------------------------
// status register flag positions and reset values
// ----------------------------------------------------------------------------
`define BRFU_FLAG_C        0
`define BRFU_FLAG_Z        1
`define BRFU_FLAG_N        2
`define BRFU_FLAG_V        3
`define BRFU_FLAG_S        4
`define BRFU_FLAG_H        5
`define BRFU_FLAG_T        6
`define BRFU_FLAG_I        7
`define BRFU_STATUS_RESET  8'h00
`define BRFU_IO_BANK_BIT   1'b1
`define BRFU_WORK_BANK_BIT 1'b0

`endif

// [hdl/brfu_pkg.sv]
/*
 * Types of the bit rotate and flag unit: operation codes, states, state record.
 * Assumes brfu_defines.svh is on the include path.
 */
`default_nettype none

package brfu_pkg;

    `include "brfu_defines.svh"

    typedef enum logic [3:0] {
        BRFU_OP_NONE        = 4'h0,
        BRFU_OP_ROTL        = 4'h1,
        BRFU_OP_ROTR        = 4'h2,
        BRFU_OP_ARITH_SHR   = 4'h3,
        BRFU_OP_SWAP        = 4'h4,
        BRFU_OP_IO_SET      = 4'h5,
        BRFU_OP_IO_CLEAR    = 4'h6,
        BRFU_OP_BIT_TO_T    = 4'h7,
        BRFU_OP_T_TO_BIT    = 4'h8,
        BRFU_OP_S_SET       = 4'h9,
        BRFU_OP_S_CLEAR     = 4'ha,
        BRFU_OP_V_SET       = 4'hb,
        BRFU_OP_V_CLEAR     = 4'hc,
        BRFU_OP_H_SET       = 4'hd,
        BRFU_OP_H_CLEAR     = 4'he
    } brfu_op_t;

    typedef enum logic [1:0] {
        BRFU_ST_IDLE = 2'b01,
        BRFU_ST_EXEC = 2'b10
    } brfu_state_t;

    typedef struct packed {
        brfu_state_t state;
        logic [7:0]  status;
        brfu_op_t    op;
        logic [2:0]  idx;
        logic [2:0]  bitn;
        logic        rd_valid;
    } brfu_regs_t;

endpackage : brfu_pkg

`default_nettype wire

// [hdl/brfu_mem.sv]
/*
 * Small register memory: working registers and I/O registers, one write port
 * and one read port whose data come out of a register one cycle later.
 * Assumes a single clock; no reset, contents are undefined until written.
 */
`timescale 1ns/10ps
`default_nettype none

module brfu_mem (
    input  wire logic       clk,
    input  wire logic       we,
    input  wire logic [3:0] waddr,
    input  wire logic [7:0] wdata,
    input  wire logic [3:0] raddr,
    output var  logic [7:0] rdata
);

    logic [7:0] cells [0:15];

    always_ff @(posedge clk) begin
        if (we) begin
            cells[waddr] <= wdata;
        end
        rdata <= cells[raddr];
    end

endmodule : brfu_mem

`default_nettype wire

// [hdl/brfu_top.sv]
/*
 * Bit rotate and flag unit: executes rotate, shift, swap, I/O bit set/clear,
 * transfer-flag moves and status flag set/clear, each in one execute clock.
 * Assumes an APB master on the same clock; working registers 0..7 and I/O
 * registers 0..7 live in brfu_mem and are reached through APB as well.
 */
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none

`include "brfu_defines.svh"

module brfu_top (
    input  wire logic        CLK,
    input  wire logic        SRST,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output var  logic [31:0] PRDATA,
    output var  logic        PREADY,
    output var  logic        PSLVERR
);
    import brfu_pkg::*;

    brfu_regs_t st;
    brfu_regs_t next_st;

    logic       is_cmd;
    logic       is_status;
    logic       is_mem;
    logic [3:0] apb_idx;
    logic [4:0] apb_word;
    logic       accept_cmd;
    logic       mem_we;
    logic [3:0] mem_waddr;
    logic [7:0] mem_wdata;
    logic [3:0] mem_raddr;
    logic [7:0] mem_rdata;
    logic [7:0] res;
    logic [7:0] flags;
    logic [3:0] cmd_op;
    logic [2:0] cmd_idx;
    logic [2:0] cmd_bit;
    logic       apb_acc;
    logic       in_exec;

    // ------------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------------
    assign in_exec   = (st.state == BRFU_ST_EXEC);
    assign apb_word  = PADDR[6:2] - `BRFU_MEM_IDX_BASE;
    assign apb_idx   = apb_word[3:0];
    assign is_cmd    = (PADDR == `BRFU_ADDR_CMD);
    assign is_status = (PADDR == `BRFU_ADDR_STATUS);
    assign is_mem    = (PADDR >= `BRFU_ADDR_MEM_LO) && (PADDR <= `BRFU_ADDR_MEM_HI)
                       && (PADDR[1:0] == 2'b00);
    assign apb_acc   = PSEL && PENABLE && PREADY;
    assign accept_cmd = apb_acc && PWRITE && is_cmd;
    assign cmd_op    = PWDATA[`BRFU_CMD_OP_MSB:`BRFU_CMD_OP_LSB];
    assign cmd_idx   = PWDATA[`BRFU_CMD_IDX_MSB:`BRFU_CMD_IDX_LSB];
    assign cmd_bit   = PWDATA[`BRFU_CMD_BIT_MSB:`BRFU_CMD_BIT_LSB];

    // mem reads wait one cycle for registered data; busy while executing
    assign PREADY  = !in_exec && !(PSEL && is_mem && !PWRITE && !st.rd_valid);
    assign PSLVERR = PSEL && PENABLE && PREADY && !(is_cmd || is_status || is_mem);

    always_comb begin
        PRDATA = 32'h0;
        if (is_cmd) begin
            PRDATA[`BRFU_CMD_OP_MSB:`BRFU_CMD_OP_LSB]   = st.op;
            PRDATA[`BRFU_CMD_IDX_MSB:`BRFU_CMD_IDX_LSB] = st.idx;
            PRDATA[`BRFU_CMD_BIT_MSB:`BRFU_CMD_BIT_LSB] = st.bitn;
        end else if (is_status) begin
            PRDATA[7:0] = st.status;
        end else if (is_mem) begin
            PRDATA[7:0] = mem_rdata;
        end
    end

    // ------------------------------------------------------------------------
    // operand fetch: the accepted command points the read port at its target
    // ------------------------------------------------------------------------
    always_comb begin
        mem_raddr = apb_idx;
        if (accept_cmd) begin
            if ((cmd_op == BRFU_OP_IO_SET) || (cmd_op == BRFU_OP_IO_CLEAR)) begin
                mem_raddr = {`BRFU_IO_BANK_BIT, cmd_idx};
            end else begin
                mem_raddr = {`BRFU_WORK_BANK_BIT, cmd_idx};
            end
        end
    end

    // ------------------------------------------------------------------------
    // execute datapath
    // ------------------------------------------------------------------------
    always_comb begin
        res   = mem_rdata;
        flags = st.status;
        case (st.op)
            BRFU_OP_ROTL: begin
                res = {mem_rdata[6:0], st.status[`BRFU_FLAG_C]};
                flags[`BRFU_FLAG_H] = mem_rdata[3];
                flags[`BRFU_FLAG_C] = mem_rdata[7];
            end
            BRFU_OP_ROTR: begin
                res = {st.status[`BRFU_FLAG_C], mem_rdata[7:1]};
                flags[`BRFU_FLAG_C] = mem_rdata[0];
            end
            BRFU_OP_ARITH_SHR: begin
                res = {mem_rdata[7], mem_rdata[7:1]};
                flags[`BRFU_FLAG_C] = mem_rdata[0];
            end
            BRFU_OP_SWAP:     res = {mem_rdata[3:0], mem_rdata[7:4]};
            BRFU_OP_IO_SET:   res[st.bitn] = 1'b1;
            BRFU_OP_IO_CLEAR: res[st.bitn] = 1'b0;
            BRFU_OP_BIT_TO_T: flags[`BRFU_FLAG_T] = mem_rdata[st.bitn];
            BRFU_OP_T_TO_BIT: res[st.bitn] = st.status[`BRFU_FLAG_T];
            BRFU_OP_S_SET:    flags[`BRFU_FLAG_S] = 1'b1;
            BRFU_OP_S_CLEAR:  flags[`BRFU_FLAG_S] = 1'b0;
            BRFU_OP_V_SET:    flags[`BRFU_FLAG_V] = 1'b1;
            BRFU_OP_V_CLEAR:  flags[`BRFU_FLAG_V] = 1'b0;
            BRFU_OP_H_SET:    flags[`BRFU_FLAG_H] = 1'b1;
            BRFU_OP_H_CLEAR:  flags[`BRFU_FLAG_H] = 1'b0;
            default:          res = mem_rdata;
        endcase
        if ((st.op == BRFU_OP_ROTL) || (st.op == BRFU_OP_ROTR)
                || (st.op == BRFU_OP_ARITH_SHR)) begin
            flags[`BRFU_FLAG_Z] = (res == 8'h00);
            flags[`BRFU_FLAG_N] = res[7];
            flags[`BRFU_FLAG_V] = res[7] ^ flags[`BRFU_FLAG_C];
        end
    end

    // ------------------------------------------------------------------------
    // write port: execute write-back, else apb writes
    // ------------------------------------------------------------------------
    always_comb begin
        mem_we    = 1'b0;
        mem_waddr = apb_idx;
        mem_wdata = PWDATA[7:0];
        if (in_exec) begin
            mem_waddr = {((st.op == BRFU_OP_IO_SET) || (st.op == BRFU_OP_IO_CLEAR)), st.idx};
            mem_wdata = res;
            case (st.op)
                BRFU_OP_ROTL, BRFU_OP_ROTR, BRFU_OP_ARITH_SHR, BRFU_OP_SWAP,
                BRFU_OP_IO_SET, BRFU_OP_IO_CLEAR, BRFU_OP_T_TO_BIT: mem_we = 1'b1;
                default: mem_we = 1'b0;
            endcase
        end else if (apb_acc && PWRITE && is_mem) begin
            mem_we = 1'b1;
        end
    end

    brfu_mem u_mem (
        .clk   (CLK),
        .we    (mem_we),
        .waddr (mem_waddr),
        .wdata (mem_wdata),
        .raddr (mem_raddr),
        .rdata (mem_rdata)
    );

    // ------------------------------------------------------------------------
    // state update
    // ------------------------------------------------------------------------
    always_comb begin
        next_st          = st;
        next_st.rd_valid = PSEL && is_mem && !in_exec && !accept_cmd;
        case (st.state)
            BRFU_ST_IDLE: begin
                if (accept_cmd) begin
                    next_st.op    = brfu_op_t'(cmd_op);
                    next_st.idx   = cmd_idx;
                    next_st.bitn  = cmd_bit;
                    next_st.state = BRFU_ST_EXEC;
                end else if (apb_acc && PWRITE && is_status) begin
                    next_st.status = PWDATA[7:0];
                end
            end
            BRFU_ST_EXEC: begin
                next_st.status = flags;
                next_st.state  = BRFU_ST_IDLE;
            end
            default: next_st.state = BRFU_ST_IDLE;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            st <= '{state: BRFU_ST_IDLE, status: `BRFU_STATUS_RESET, op: BRFU_OP_NONE,
                    idx: 3'h0, bitn: 3'h0, rd_valid: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    rotl_result_a: assert property (@(posedge CLK) disable iff (SRST)
        in_exec && st.op == BRFU_OP_ROTL |-> mem_we && mem_wdata ==
        {mem_rdata[6:0], st.status[`BRFU_FLAG_C]}
        ##1 st.status[`BRFU_FLAG_C] == $past(mem_rdata[7])
        && st.status[`BRFU_FLAG_H] == $past(mem_rdata[3]))
        else $error("rotate left result or flags wrong");
    rotr_result_a: assert property (@(posedge CLK) disable iff (SRST)
        in_exec && st.op == BRFU_OP_ROTR |-> mem_wdata[7] == st.status[`BRFU_FLAG_C]
        ##1 st.status[`BRFU_FLAG_C] == $past(mem_rdata[0])
        && st.status[`BRFU_FLAG_H] == $past(st.status[`BRFU_FLAG_H]))
        else $error("rotate right result or flags wrong");
    io_set_a: assert property (@(posedge CLK) disable iff (SRST)
        in_exec && st.op == BRFU_OP_IO_SET |-> mem_waddr[3] && mem_wdata[st.bitn]
        ##1 st.status == $past(st.status))
        else $error("io bit set wrong");
    io_clear_a: assert property (@(posedge CLK) disable iff (SRST)
        in_exec && st.op == BRFU_OP_IO_CLEAR |-> !mem_wdata[st.bitn]
        && (mem_wdata | (8'h01 << st.bitn)) == (mem_rdata | (8'h01 << st.bitn)))
        else $error("io bit clear wrong");
    bit_store_a: assert property (@(posedge CLK) disable iff (SRST)
        in_exec && st.op == BRFU_OP_BIT_TO_T |-> !mem_we ##1
        st.status[`BRFU_FLAG_T] == $past(mem_rdata[st.bitn]))
        else $error("bit store to transfer flag wrong");
    bit_load_a: assert property (@(posedge CLK) disable iff (SRST)
        in_exec && st.op == BRFU_OP_T_TO_BIT |-> mem_wdata[st.bitn] == st.status[`BRFU_FLAG_T]
        ##1 st.status == $past(st.status))
        else $error("bit load from transfer flag wrong");
    signed_flag_a: assert property (@(posedge CLK) disable iff (SRST)
        in_exec && st.op == BRFU_OP_S_SET |=> st.status[`BRFU_FLAG_S]
        && st.status[3:0] == $past(st.status[3:0]))
        else $error("signed flag set wrong");
    overflow_flag_a: assert property (@(posedge CLK) disable iff (SRST)
        in_exec && st.op == BRFU_OP_V_CLEAR |=> !st.status[`BRFU_FLAG_V]
        && st.status[`BRFU_FLAG_S] == $past(st.status[`BRFU_FLAG_S]))
        else $error("overflow flag clear wrong");
    half_flag_a: assert property (@(posedge CLK) disable iff (SRST)
        in_exec && st.op == BRFU_OP_H_SET |=> st.status[`BRFU_FLAG_H] && !in_exec)
        else $error("half carry set wrong");
    arith_shift_a: assert property (@(posedge CLK) disable iff (SRST)
        in_exec && st.op == BRFU_OP_ARITH_SHR |-> mem_wdata == {mem_rdata[7], mem_rdata[7:1]}
        ##1 st.status[`BRFU_FLAG_C] == $past(mem_rdata[0]))
        else $error("arithmetic shift wrong");
    swap_nibble_a: assert property (@(posedge CLK) disable iff (SRST)
        in_exec && st.op == BRFU_OP_SWAP |-> mem_wdata == {mem_rdata[3:0], mem_rdata[7:4]}
        ##1 st.status == $past(st.status))
        else $error("nibble swap wrong");

endmodule : brfu_top

`default_nettype wire

// [tb/brfu_apb_master.sv]
/*
 * APB master model standing in for the core side of the unit.
 * Assumes one clock; the bench asks for a transfer with a start pulse.
 */
`timescale 1ns/10ps
`default_nettype none

module brfu_apb_master (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        start,
    input  wire logic        wr,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr,
    output var  logic        psel,
    output var  logic        penable,
    output var  logic        pwrite,
    output var  logic [7:0]  paddr,
    output var  logic [31:0] pwdata,
    output var  logic        done,
    output var  logic [31:0] rdata,
    output var  logic        err
);
    initial begin
        {psel, penable, pwrite, done, err} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        rdata = 32'h0;
    end

    // bus released after a completed transfer shows inverted values, never the last request; reset leaves them as they were
    always @(posedge clk) begin
        done <= 1'b0;
        if (srst) begin
            psel <= 1'b0;
            penable <= 1'b0;
        end else if (start && !psel) begin
            psel <= 1'b1;
            pwrite <= wr;
            paddr <= addr;
            pwdata <= wdata;
        end else if (psel && !penable) begin
            penable <= 1'b1;
        end else if (psel && pready) begin
            psel <= 1'b0;
            penable <= 1'b0;
            pwrite <= ~pwrite;
            paddr <= ~paddr;
            pwdata <= ~pwdata;
            done <= 1'b1;
            rdata <= prdata;
            err <= pslverr;
        end
    end
endmodule : brfu_apb_master

`default_nettype wire

// [tb/bit_rotate_flag_unit_test.sv]
/*
 * Self-checking bench: runs every operation through the APB model.
 * Assumes brfu_pkg, brfu_top and brfu_apb_master are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none

module bit_rotate_flag_unit_test;
    import brfu_pkg::*;
    logic        clk, srst, start, wr, done, err;
    logic        psel, penable, pwrite, pready, pslverr;
    logic [7:0]  addr, paddr;
    logic [31:0] wdata, rdata, pwdata, prdata;
    int          failures, compares;
    brfu_op_t    sh_ops[4] = '{BRFU_OP_ROTL, BRFU_OP_ROTR, BRFU_OP_ARITH_SHR, BRFU_OP_SWAP};
    logic [7:0]  vals[4] = '{8'h88, 8'h00, 8'h01, 8'h7f};
    logic [7:0]  sts[4] = '{8'h70, 8'h71, 8'h00, 8'h8f};
    int          fbit[6] = '{4, 4, 3, 3, 5, 5};

    always #25 clk = ~clk;

    brfu_apb_master i_master (.clk(clk), .srst(srst), .start(start), .wr(wr), .addr(addr),
        .wdata(wdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .done(done),
        .rdata(rdata), .err(err));

    brfu_top i_dut (.CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));

    // ----------------------------------------------------------------
    // access and compare tasks
    // ----------------------------------------------------------------
    task results;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : results

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        start <= 1'b1;
        wr <= w;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        start <= 1'b0;
        for (n = 0; n < 20; n++) begin
            @(negedge clk);
            if (done === 1'b1) break;
        end
        if (n == 20) begin
            failures++;
            $display("mismatch at %0t: no answer at address %h", $time, a);
            results();
        end
    endtask : apb

    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0);
        chk(rdata, exp, what);
    endtask : rd

    // preload register and status, run one command, read both back
    task run(input brfu_op_t op, input logic [7:0] a, input logic [2:0] bitn,
             input logic [7:0] d, input logic [7:0] st, input logic [7:0] exp_d,
             input logic [7:0] exp_st);
        apb(1'b1, a, {24'h0, d});
        apb(1'b1, 8'h04, {24'h0, st});
        apb(1'b1, 8'h00, {21'h0, bitn, 1'b0, a[4:2], op});
        rd(a, {24'h0, exp_d}, "register");
        rd(8'h04, {24'h0, exp_st}, "status");
    endtask : run

    function automatic logic [15:0] shift_ref(input brfu_op_t op, input logic [7:0] d,
                                              input logic [7:0] st);
        logic [7:0] r;
        logic [7:0] s;
        s = st;
        case (op)
            BRFU_OP_ROTL: begin
                r = {d[6:0], st[0]};
                s[0] = d[7];
                s[5] = d[3];
            end
            BRFU_OP_ROTR: begin
                r = {st[0], d[7:1]};
                s[0] = d[0];
            end
            BRFU_OP_ARITH_SHR: begin
                r = {d[7], d[7:1]};
                s[0] = d[0];
            end
            default: r = {d[3:0], d[7:4]};
        endcase
        if (op != BRFU_OP_SWAP) begin
            s[1] = (r == 8'h00);
            s[2] = r[7];
            s[3] = r[7] ^ s[0];
        end
        return {r, s};
    endfunction : shift_ref

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [15:0] e;
        logic [7:0]  m;
        clk = 1'b0;
        srst = 1'b1;
        start = 1'b0;
        wr = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        failures = 0;
        compares = 0;
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        rd(8'h04, 32'h0, "status after reset");
        chk({31'h0, err}, 32'h0, "mapped access error");
        apb(1'b1, 8'h10, 32'hff);
        chk({31'h0, err}, 32'h1, "unmapped write error");
        rd(8'h10, 32'h0, "unmapped read");
        chk({31'h0, err}, 32'h1, "unmapped error");
        $display("test access done");
        for (int i = 0; i < 4; i++) begin
            for (int j = 0; j < 4; j++) begin
                e = shift_ref(sh_ops[i], vals[j], sts[j]);
                run(sh_ops[i], 8'(8'h20 + 4 * j), 3'd0, vals[j], sts[j],
                    e[15:8], e[7:0]);
            end
        end
        $display("test shifts done");
        apb(1'b1, 8'h2c, 32'h33);
        run(BRFU_OP_IO_SET, 8'h4c, 3'd0, 8'h5a, 8'hff, 8'h5b, 8'hff);
        rd(8'h2c, 32'h33, "working register beside io");
        run(BRFU_OP_IO_SET, 8'h44, 3'd7, 8'h5a, 8'h00, 8'hda, 8'h00);
        run(BRFU_OP_IO_CLEAR, 8'h5c, 3'd7, 8'hff, 8'h2a, 8'h7f, 8'h2a);
        run(BRFU_OP_IO_CLEAR, 8'h40, 3'd0, 8'h01, 8'hd5, 8'h00, 8'hd5);
        $display("test io bits done");
        run(BRFU_OP_BIT_TO_T, 8'h34, 3'd7, 8'h80, 8'h3f, 8'h80, 8'h7f);
        run(BRFU_OP_BIT_TO_T, 8'h20, 3'd0, 8'hfe, 8'hff, 8'hfe, 8'hbf);
        run(BRFU_OP_T_TO_BIT, 8'h38, 3'd7, 8'h00, 8'h40, 8'h80, 8'h40);
        run(BRFU_OP_T_TO_BIT, 8'h3c, 3'd0, 8'hff, 8'hbf, 8'hfe, 8'hbf);
        $display("test transfer flag done");
        for (int k = 0; k < 6; k++) begin
            m = 8'h01 << fbit[k];
            run(brfu_op_t'(4'h9 + 4'(k)), 8'h24, 3'd0, 8'ha5, k[0] ? 8'hff : 8'h00,
                8'ha5, k[0] ? ~m : m);
        end
        run(BRFU_OP_NONE, 8'h28, 3'd0, 8'h3c, 8'h55, 8'h3c, 8'h55);
        rd(8'h00, 32'h0000_0020, "command readback");
        $display("test flags done");
        results();
    end
endmodule : bit_rotate_flag_unit_test

`default_nettype wire
